// file: tb/async_slave_fifo_write_tb.sv
`timescale 1ns/100ps
`default_nettype none
module async_slave_fifo_write_tb;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    // Polarity is static; it only changes under reset
    logic pol_wr = 1'b0;
    logic pol_cm = 1'b0;
    logic [1:0] sel = 2'h0;
    logic valid = 1'b0;
    logic [7:0] din = 8'h00;
    logic last = 1'b0;
    logic [3:0] drain = 4'h0;
    logic ready;
    logic [3:0] pkt_valid;
    logic [3:0] full;
    logic [19:0] pkt_len;
    logic [15:0] wptr;
    logic wr_prev = 1'b0;
    int n_edges = 0;
    int errors = 0;
    int n_compared = 0;
    always #2 i_clk = ~i_clk;
    fifo_wr_if u_fifo_wr_if ();
    fifo_wr_master u_fifo_wr_master (.i_clk(i_clk), .i_rst(i_rst),
        .bus(u_fifo_wr_if), .i_wr_active_high(pol_wr),
        .i_commit_active_high(pol_cm), .i_sel(sel), .i_valid(valid),
        .o_ready(ready), .i_data(din), .i_last(last), .o_busy());
    fifo_wr_device u_fifo_wr_device (.i_clk(i_clk), .i_rst(i_rst),
        .bus(u_fifo_wr_if), .i_wr_active_high(pol_wr),
        .i_commit_active_high(pol_cm), .i_drain(drain),
        .o_pkt_valid(pkt_valid), .o_pkt_len(pkt_len), .o_full(full),
        .o_wptr(wptr));
    fifo_wr_asserts u_fifo_wr_asserts (.i_clk(i_clk), .i_rst(i_rst),
        .i_wr_active_high(pol_wr), .i_commit_active_high(pol_cm),
        .port_select_n(u_fifo_wr_if.port_select_n),
        .fifo_write_strobe(u_fifo_wr_if.fifo_write_strobe),
        .packet_commit_strobe(u_fifo_wr_if.packet_commit_strobe),
        .fifo_select_lines(u_fifo_wr_if.fifo_select_lines),
        .data(u_fifo_wr_if.data), .full_flags(u_fifo_wr_if.full_flags));
    // Count trailing edges of the write strobe seen on the wire
    always @(posedge i_clk) begin
        wr_prev <= u_fifo_wr_if.fifo_write_strobe == pol_wr;
        if (wr_prev && u_fifo_wr_if.fifo_write_strobe != pol_wr) begin
            n_edges <= n_edges + 1;
        end
    end
    task check(input string what, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %0h seen %0h", what, e, g);
        end
    endtask : check
    task print_verdict();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict
    task timed_out(input string what);
        errors++;
        $display("MISMATCH %s expected done seen timeout", what);
        print_verdict();
    endtask : timed_out
    task do_reset();
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
    endtask : do_reset
    // Stream n bytes into the master, then wait for the commit
    task send(input logic [1:0] s, input int n);
        int t;
        int base;
        @(posedge i_clk);
        sel <= s;
        base = n_edges;
        for (int k = 0; k < n; k++) begin
            valid <= 1'b1;
            din <= 8'hA0 + 8'(k);
            last <= k == n - 1;
            t = 0;
            // Ready is settled at the falling edge before it is sampled
            do begin
                @(negedge i_clk);
                if (++t > 1000) timed_out("stream ready");
            end while (ready !== 1'b1);
            @(posedge i_clk);
        end
        valid <= 1'b0;
        t = 0;
        while (pkt_valid[s] !== 1'b1) begin
            @(posedge i_clk);
            if (++t > 4000) timed_out("packet commit");
        end
        @(negedge i_clk);
        check("commit flag", 16'h1, 16'(pkt_valid[s]));
        check("packet length", 16'(n), 16'(pkt_len[s*5+:5]));
        check("write pointer", 16'(n % 16), 16'(wptr[s*4+:4]));
        check("full flag", 16'(n == 16), 16'(full[s]));
        check("strobe count", 16'(n), 16'(n_edges - base));
        $display("packet of %0d bytes to fifo %0d done", n, s);
    endtask : send
    task t_full_drain();
        int t;
        send(2'h3, 16);
        @(posedge i_clk);
        drain <= 4'h8;
        @(posedge i_clk);
        drain <= 4'h0;
        t = 0;
        while (full[3] !== 1'b0) begin
            @(posedge i_clk);
            if (++t > 100) timed_out("drain");
        end
        @(negedge i_clk);
        check("flag after drain", 16'h0, 16'(pkt_valid[3]));
        check("wire full flag", 16'h0, 16'(u_fifo_wr_if.full_flags));
        $display("full and drain test done");
    endtask : t_full_drain
    task t_polarity();
        pol_wr <= 1'b1;
        pol_cm <= 1'b1;
        do_reset();
        @(negedge i_clk);
        check("idle write level", 16'h0,
            16'(u_fifo_wr_if.fifo_write_strobe));
        check("idle commit level", 16'h0,
            16'(u_fifo_wr_if.packet_commit_strobe));
        send(2'h2, 3);
        $display("polarity test done");
    endtask : t_polarity
    initial begin
        do_reset();
        @(negedge i_clk);
        check("idle select", 16'h1, 16'(u_fifo_wr_if.port_select_n));
        check("idle write level", 16'h1,
            16'(u_fifo_wr_if.fifo_write_strobe));
        send(2'h0, 1);
        send(2'h1, 4);
        t_full_drain();
        t_polarity();
        print_verdict();
    end
endmodule : async_slave_fifo_write_tb
`default_nettype wire

// file: tb/fifo_wr_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module fifo_wr_asserts (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_wr_active_high,
    input wire logic i_commit_active_high,
    input wire logic port_select_n,
    input wire logic fifo_write_strobe,
    input wire logic packet_commit_strobe,
    input wire logic [fifo_wr_pkg::SEL_W-1:0] fifo_select_lines,
    input wire logic [fifo_wr_pkg::DATA_W-1:0] data,
    input wire logic [fifo_wr_pkg::NUM_FIFOS-1:0] full_flags
);
    // Strobes decoded against the configured polarity
    logic wr_on;
    logic cm_on;
    // Idle cycles since the last write strobe, saturating
    logic [3:0] gap_q;
    logic [3:0] gap_d;
    assign wr_on = fifo_write_strobe == i_wr_active_high;
    assign cm_on = packet_commit_strobe == i_commit_active_high;
    // Saturate so a long idle never wraps back to a short gap
    always_comb begin
        gap_d = wr_on ? 4'h0 : gap_q + {3'h0, gap_q != 4'hF};
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            gap_q <= 4'h0;
        end else begin
            gap_q <= gap_d;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    chk_strobes_exclusive: assert property (!(wr_on && cm_on))
        else $error("write and commit strobes overlap");
    chk_select_leads: assert property (
        $rose(wr_on) |-> !port_select_n && $past(!port_select_n))
        else $error("select not ahead of write strobe");
    chk_addr_setup: assert property (
        $rose(wr_on) |-> fifo_select_lines == $past(fifo_select_lines, 4))
        else $error("fifo select not settled before strobe");
    chk_write_held: assert property (
        wr_on && $past(wr_on) |-> $stable(data) && $stable(fifo_select_lines))
        else $error("data or select moved during write strobe");
    chk_commit_addr: assert property (
        cm_on && $past(cm_on) |-> $stable(fifo_select_lines))
        else $error("fifo select moved during commit");
    chk_strobe_width: assert property ($rose(wr_on) |-> wr_on [*5])
        else $error("write strobe pulse too short");
    chk_commit_gap: assert property (
        $rose(cm_on) |-> gap_q >= fifo_wr_pkg::PULSE_HI_CYC)
        else $error("commit too soon after write strobe");
    chk_idle_unsel: assert property (port_select_n |-> !wr_on && !cm_on)
        else $error("strobe active while unselected");
    chk_full_cause: assert property (
        $rose(|full_flags) |-> $past(wr_on, 2) || $past(wr_on, 3)
        || $past(wr_on, 4))
        else $error("full flag rose without a write");
    cov_write: cover property ($fell(wr_on));
    cov_commit: cover property ($rose(cm_on));
    cov_full: cover property ($rose(|full_flags));
endmodule : fifo_wr_asserts
`default_nettype wire

// file: verilog/fifo_wr_device.sv
// Overview of operation
// - Master sets address, select before strobing
// - Select asserted with or before strobe
// - Byte captured on strobe trailing edge
// - Pointer advances after byte stored
// - Flags refresh from strobe trailing edge
// - Each burst strobe stores one byte
// - Commit strobe sends short packet
// - Never both strobes active together
// - Commit only after strobe inactive time
// - Select lines steady during commit
// - Strobe polarity is configurable
`timescale 1ns/100ps
`default_nettype none
module fifo_wr_device (
    input wire logic i_clk,
    input wire logic i_rst,
    fifo_wr_if.device bus,
    input wire logic i_wr_active_high,
    input wire logic i_commit_active_high,
    input wire logic [fifo_wr_pkg::NUM_FIFOS-1:0] i_drain,
    output logic [fifo_wr_pkg::NUM_FIFOS-1:0] o_pkt_valid,
    output logic [4*fifo_wr_pkg::CNT_W-1:0] o_pkt_len,
    output logic [fifo_wr_pkg::NUM_FIFOS-1:0] o_full,
    output logic [fifo_wr_pkg::NUM_FIFOS*fifo_wr_pkg::PTR_W-1:0] o_wptr
);
    // Short local names for the package widths
    localparam int NF = fifo_wr_pkg::NUM_FIFOS;
    localparam int PW = fifo_wr_pkg::PTR_W;
    localparam int CW = fifo_wr_pkg::CNT_W;
    localparam int SW = fifo_wr_pkg::SEL_W;
    localparam int DW = fifo_wr_pkg::DATA_W;

    // Endpoint storage, all FIFOs in one array
    // Upper address bits pick the FIFO, lower bits the slot
    logic [DW-1:0] mem [NF*fifo_wr_pkg::EP_DEPTH];

    // Write strobe level seen on the previous edge
    logic wr_prev_q;
    // Next value of the write strobe history
    logic wr_prev_d;
    // Commit strobe level seen on the previous edge
    logic cm_prev_q;
    // Next value of the commit strobe history
    logic cm_prev_d;
    // Write strobe decoded to active-true
    logic wr_act;
    // Commit strobe decoded to active-true
    logic cm_act;
    // Write strobe released on this edge
    logic wr_fall;
    // Commit strobe released on this edge
    logic cm_fall;
    // Port selected by the master
    logic sel_ok;

    // Per-FIFO write pointers
    logic [PW-1:0] wptr_q [NF];
    // Next write pointers
    logic [PW-1:0] wptr_d [NF];
    // Per-FIFO byte counts; one bit wider to hold a full FIFO
    logic [CW-1:0] cnt_q [NF];
    // Next byte counts
    logic [CW-1:0] cnt_d [NF];
    // Committed packet flags, sticky until drained
    logic [NF-1:0] pend_q;
    // Next committed packet flags
    logic [NF-1:0] pend_d;
    // Full flags, registered so the pins come from flops
    logic [NF-1:0] full_q;
    // Next full flags
    logic [NF-1:0] full_d;
    // FIFO addressed by the select lines
    logic [SW-1:0] idx;
    // A byte is taken on this edge
    logic do_write;

    // True when the select lines address endpoint number n
    function automatic logic addressed(input logic [SW-1:0] sel,
            input int n);
        addressed = (sel == n[SW-1:0]);
    endfunction : addressed

    // polarity applied
    // XNOR turns either polarity into an active-true level
    assign wr_act = bus.fifo_write_strobe ~^ i_wr_active_high;
    assign cm_act = bus.packet_commit_strobe ~^ i_commit_active_high;
    // Select is always active low
    assign sel_ok = !bus.port_select_n;
    assign idx = bus.fifo_select_lines;

    // trailing edge detect
    // History resets to inactive, so no false edge after reset
    assign wr_fall = wr_prev_q && !wr_act;
    assign cm_fall = cm_prev_q && !cm_act;

    // ignore if unselected or full
    // A refused strobe stores nothing and moves no pointer
    assign do_write = wr_fall && sel_ok && !full_q[idx];

    // Next state of pointers, counts and flags
    always_comb begin
        // Edge history simply follows the decoded strobes
        wr_prev_d = wr_act;
        cm_prev_d = cm_act;
        // Drain clears a flag; a commit below sets it again
        pend_d = pend_q & ~i_drain;
        for (int i = 0; i < NF; i++) begin
            // Default: hold, or empty on drain
            wptr_d[i] = wptr_q[i];
            cnt_d[i] = i_drain[i] ? fifo_wr_pkg::CNT_RST : cnt_q[i];
            // post-increment pointer
            // Pointer moves after the byte lands at the old slot
            if (do_write && addressed(idx, i)) begin
                wptr_d[i] = wptr_q[i] + 1'b1;
                cnt_d[i] = cnt_q[i] + 1'b1;
            end
            // commit on release
            // Set wins over a drain in the same cycle
            if (cm_fall && sel_ok && addressed(idx, i)) begin
                pend_d[i] = 1'b1;
            end
            // flags follow counts
            // Flag changes on the same edge as the trailing edge sample
            full_d[i] = (cnt_d[i] == fifo_wr_pkg::EP_DEPTH[CW-1:0]);
        end
    end

    // Register all state except storage; flags refresh on the same edge as the write
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_prev_q <= 1'b0;
            cm_prev_q <= 1'b0;
            pend_q <= '0;
            full_q <= '0;
            for (int i = 0; i < NF; i++) begin
                wptr_q[i] <= fifo_wr_pkg::PTR_RST;
                cnt_q[i] <= fifo_wr_pkg::CNT_RST;
            end
        end else begin
            wr_prev_q <= wr_prev_d;
            cm_prev_q <= cm_prev_d;
            pend_q <= pend_d;
            full_q <= full_d;
            for (int i = 0; i < NF; i++) begin
                wptr_q[i] <= wptr_d[i];
                cnt_q[i] <= cnt_d[i];
            end
        end
    end

    // store byte per strobe
    // Storage has no reset; only written slots are ever used
    always_ff @(posedge i_clk) begin
        if (do_write) begin
            mem[{idx, wptr_q[idx]}] <= bus.data;
        end
    end

    // Outputs straight from flops
    // Wire flags and the local copy carry the same register
    assign bus.full_flags = full_q;
    assign o_full = full_q;
    assign o_pkt_valid = pend_q;
    // Pack per-FIFO counts and pointers into flat buses
    genvar g;
    generate
        for (g = 0; g < NF; g++) begin : g_out
            assign o_pkt_len[g*CW +: CW] = cnt_q[g];
            assign o_wptr[g*PW +: PW] = wptr_q[g];
        end
    endgenerate
endmodule : fifo_wr_device
`default_nettype wire

// file: verilog/fifo_wr_if.sv
`timescale 1ns/100ps
`default_nettype none
interface fifo_wr_if;
    // Active-low port select from the master
    logic port_select_n;
    // Write strobe and commit strobe, polarity set at both ends
    logic fifo_write_strobe;
    logic packet_commit_strobe;
    // Endpoint FIFO select and data bus
    logic [fifo_wr_pkg::SEL_W-1:0] fifo_select_lines;
    logic [fifo_wr_pkg::DATA_W-1:0] data;
    // Full flags per FIFO, driven by the device
    logic [fifo_wr_pkg::NUM_FIFOS-1:0] full_flags;
    modport device (
        input port_select_n, fifo_write_strobe, packet_commit_strobe,
        input fifo_select_lines, data,
        output full_flags
    );
    modport master (
        output port_select_n, fifo_write_strobe, packet_commit_strobe,
        output fifo_select_lines, data,
        input full_flags
    );
endinterface : fifo_wr_if
`default_nettype wire

// file: verilog/fifo_wr_master.sv
`timescale 1ns/100ps
`default_nettype none
module fifo_wr_master (
    input wire logic i_clk,
    input wire logic i_rst,
    fifo_wr_if.master bus,
    input wire logic i_wr_active_high,
    input wire logic i_commit_active_high,
    input wire logic [fifo_wr_pkg::SEL_W-1:0] i_sel,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [fifo_wr_pkg::DATA_W-1:0] i_data,
    input wire logic i_last,
    output logic o_busy
);
    localparam int DW = fifo_wr_pkg::DATA_W;
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_SETUP = 5'h02,
        S_LOW = 5'h04,
        S_HIGH = 5'h08,
        S_COMMIT = 5'h10
    } state_t;
    state_t st_q, st_d;
    logic [fifo_wr_pkg::TIM_W-1:0] tim_q, tim_d;
    logic [DW-1:0] dat_q, dat_d;
    logic last_q, last_d, sel_n_q, sel_n_d, wr_q, wr_d, cm_q, cm_d;
    logic [fifo_wr_pkg::SEL_W-1:0] fsel_q, fsel_d;
    logic b_valid, b_ready, b_last;
    logic [DW:0] b_word;

    // Buffer absorbs the user stream; it stalls while strobing
    stream_buf #(.WIDTH(DW + 1), .DEPTH(fifo_wr_pkg::BUF_DEPTH)) u_buf (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_valid(i_valid),
        .o_ready(o_ready),
        .i_data({i_last, i_data}),
        .o_valid(b_valid),
        .i_ready(b_ready),
        .o_data(b_word)
    );
    assign b_last = b_word[DW];
    assign b_ready = (st_q == S_IDLE) && !bus.full_flags[i_sel];

    // Strobe sequencer
    always_comb begin
        st_d = st_q;
        tim_d = tim_q;
        dat_d = dat_q;
        last_d = last_q;
        sel_n_d = sel_n_q;
        fsel_d = fsel_q;
        wr_d = 1'b0;
        cm_d = 1'b0;
        case (st_q)
            S_IDLE: begin
                if (b_valid && b_ready) begin
                    dat_d = b_word[DW-1:0];
                    last_d = b_last;
                    fsel_d = i_sel;
                    sel_n_d = 1'b0;
                    tim_d = fifo_wr_pkg::SETUP_CYC[3:0];
                    st_d = S_SETUP;
                end
            end
            S_SETUP: begin
                tim_d = tim_q - 1'b1;
                if (tim_q == 4'h1) begin
                    tim_d = fifo_wr_pkg::PULSE_LO_CYC[3:0];
                    st_d = S_LOW;
                end
            end
            S_LOW: begin
                wr_d = 1'b1;
                tim_d = tim_q - 1'b1;
                if (tim_q == 4'h1) begin
                    tim_d = fifo_wr_pkg::PULSE_HI_CYC[3:0];
                    st_d = S_HIGH;
                end
            end
            S_HIGH: begin
                tim_d = tim_q - 1'b1;
                if (tim_q == 4'h1) begin
                    tim_d = fifo_wr_pkg::PULSE_LO_CYC[3:0];
                    st_d = last_q ? S_COMMIT : S_IDLE;
                end
            end
            S_COMMIT: begin
                cm_d = 1'b1;
                tim_d = tim_q - 1'b1;
                if (tim_q == 4'h1) begin
                    st_d = S_IDLE;
                end
            end
            default: st_d = S_IDLE;
        endcase
    end

    // Register sequencer state
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= S_IDLE;
            tim_q <= 4'h0;
            dat_q <= 8'h00;
            last_q <= 1'b0;
            sel_n_q <= 1'b1;
            fsel_q <= 2'h0;
            wr_q <= 1'b0;
            cm_q <= 1'b0;
        end else begin
            st_q <= st_d;
            tim_q <= tim_d;
            dat_q <= dat_d;
            last_q <= last_d;
            sel_n_q <= sel_n_d;
            fsel_q <= fsel_d;
            wr_q <= wr_d;
            cm_q <= cm_d;
        end
    end

    // Strobe pins apply the chosen polarity; every pin comes from a flopped level
    assign bus.port_select_n = sel_n_q;
    assign bus.fifo_select_lines = fsel_q;
    assign bus.data = dat_q;
    assign bus.fifo_write_strobe = wr_q ~^ i_wr_active_high;
    assign bus.packet_commit_strobe = cm_q ~^ i_commit_active_high;
    assign o_busy = (st_q != S_IDLE);
endmodule : fifo_wr_master
`default_nettype wire

// file: verilog/fifo_wr_pkg.sv
package fifo_wr_pkg;
    // Data bus and FIFO select widths
    localparam int DATA_W = 8;
    localparam int SEL_W = 2;
    localparam int NUM_FIFOS = 4;
    // Depth of each endpoint FIFO inside the device
    localparam int EP_DEPTH = 16;
    localparam int PTR_W = 4;
    localparam int CNT_W = 5;
    // Depth of the user-side buffer in the master
    localparam int BUF_DEPTH = 16;
    // Strobe timing in ns, counted in cycles of the 4 ns clock
    localparam int CLK_NS = 4;
    localparam int SETUP_NS = 20;
    localparam int PULSE_LO_NS = 20;
    localparam int PULSE_HI_NS = 20;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULSE_LO_CYC = (PULSE_LO_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULSE_HI_CYC = (PULSE_HI_NS + CLK_NS - 1) / CLK_NS;
    localparam int TIM_W = 4;
    // Reset values
    localparam logic [PTR_W-1:0] PTR_RST = 4'h0;
    localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
endpackage : fifo_wr_pkg

// file: verilog/stream_buf.sv
`timescale 1ns/100ps
`default_nettype none
module stream_buf #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);
    // Storage array, one word per entry
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    // Honest flags straight from the fill count
    assign o_ready = (cnt_q != DEPTH[AW:0]);
    assign o_valid = (cnt_q != '0);
    assign o_data = mem[rp_q];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    // Next pointers and count
    always_comb begin
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = pop ? rp_q + 1'b1 : rp_q;
        cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    // Register pointers
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    // Memory has no reset; only written words are ever read
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wp_q] <= i_data;
        end
    end
endmodule : stream_buf
`default_nettype wire
